// ### shared/sadc_defs.vh
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// Register indexes; byte address is four times the index
`define SADC_IDX_ALT_SWALLOW 6'h0F
`define SADC_IDX_ALT_MAIN_HI 6'h10
`define SADC_IDX_ALT_MAIN_LO 6'h11
`define SADC_IDX_ALT_REF_HI 6'h12
`define SADC_IDX_ALT_REF_LO 6'h13
`define SADC_IDX_BIAS 6'h14
`define SADC_IDX_FE_CTRL 6'h15
`define SADC_IDX_FE_VALUE 6'h16
`define SADC_IDX_MAIN_MODE 6'h17

// Writable bit masks; reserved bits are neither stored nor read back
`define SADC_MASK_SWALLOW 8'h3F
`define SADC_MASK_CNT_HI 8'h0F
`define SADC_MASK_FULL 8'hFF
`define SADC_MASK_FE_CTRL 8'h0F
`define SADC_MASK_MODE 8'h03

// Bias register field positions
`define SADC_BIAS_HALVER 7
`define SADC_BIAS_OSC_HI 6
`define SADC_BIAS_OSC_LO 5
`define SADC_BIAS_AMP_HI 4
`define SADC_BIAS_AMP_LO 3
`define SADC_BIAS_BUF_HI 2

// Main mode field bit positions in the mode register
`define SADC_MODE_HI_BIT 1
`define SADC_MODE_LO_BIT 0

// Main mode codes
`define SADC_MODE_DOWN 2'h0
`define SADC_MODE_STANDBY 2'h1
`define SADC_MODE_RX 2'h2
`define SADC_MODE_TX 2'h3

// Reset values
`define SADC_RST_ZERO 8'h00
`define SADC_RST_BIAS 8'hA3
`define SADC_RST_MODE 2'h0

`endif

// ### verif/sadc_checker.sv
// Watches the bank's bus and state outputs
module sadc_checker #(
    parameter MAIN_W = 12,
    parameter SWALLOW_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Bus
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Fields and state
    input wire logic [MAIN_W-1:0] alt_main_count,
    input wire logic [MAIN_W-1:0] alt_ref_count,
    input wire logic power_down,
    input wire logic osc_enable,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic amp_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Acked read, acked byte write, index
    wire rd = wb_ack_o & ~wb_we_i;
    wire wr = wb_ack_o & wb_we_i & wb_sel_i[0];
    wire [5:0] ix = wb_adr_i[7:2];
    wire mw = wr & (ix == 6'h17);
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_mode_down: assert property (mw && wb_dat_i[1:0] == 2'h0
        |-> ##[1:2] power_down && !rx_enable && !tx_enable) else $error("no power down");
    chk_down_keeps: assert property (power_down && !wb_ack_o
        |=> $stable(alt_main_count) && $stable(alt_ref_count)) else $error("lost count");
    chk_mode_standby: assert property (mw && wb_dat_i[1:0] == 2'h1
        |-> ##[1:2] osc_enable && !power_down) else $error("no standby");
    chk_mode_rx: assert property (mw && wb_dat_i[1:0] == 2'h2
        |-> ##[1:2] rx_enable && !tx_enable) else $error("no receive");
    chk_mode_tx: assert property (mw && wb_dat_i[1:0] == 2'h3
        |-> ##[1:2] tx_enable && !rx_enable) else $error("no transmit");
    chk_amp_off: assert property (!amp_enable)
        else $error("amplifier enabled");
    chk_main_hi: assert property (wr && ix == 6'h10
        |=> alt_main_count[11:8] == $past(wb_dat_i[3:0])) else $error("main hi");
    chk_main_lo: assert property (wr && ix == 6'h11
        |=> alt_main_count[7:0] == $past(wb_dat_i[7:0])) else $error("main lo");
    chk_ref_lo: assert property (wr && ix == 6'h13
        |=> alt_ref_count[7:0] == $past(wb_dat_i[7:0])) else $error("ref lo");
    chk_ref_hi: assert property (wr && ix == 6'h12
        |=> alt_ref_count[11:8] == $past(wb_dat_i[3:0])) else $error("ref hi");
    chk_swallow_top: assert property (rd && ix == 6'h0F |-> wb_dat_o[31:6] == 26'h0)
        else $error("swallow top bits");
    chk_fe_ctrl_top: assert property (rd && ix == 6'h15 |-> wb_dat_o[31:4] == 28'h0)
        else $error("estimator control top bits");
    chk_unmapped_zero: assert property (rd && (ix < 6'h0F || ix > 6'h17)
        |-> wb_dat_o == 32'h0) else $error("unmapped read");
    // Main scenarios
    cover property (mw);
    cover property (rd && ix == 6'h16);
    cover property (power_down && wr);
    cover property (tx_enable && !amp_enable);
endmodule // sadc_checker

bind sadc_bank sadc_checker #(.MAIN_W(MAIN_W), .SWALLOW_W(SWALLOW_W)) u_sadc_checker (
    .clock(clock), .rst_b(rst_b), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .alt_main_count(alt_main_count), .alt_ref_count(alt_ref_count),
    .power_down(power_down), .osc_enable(osc_enable), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .amp_enable(amp_enable)
);

// ### verif/sadc_host_model.sv
// Host controller: classic single-cycle bus master
module sadc_host_model (
    // Clock
    input wire logic clock,
    // Bus request
    output logic cyc = 1'b0,
    output logic stb = 1'b0,
    output logic we = 1'b0,
    output logic [7:0] adr = 8'h00,
    output logic [3:0] sel = 4'h0,
    output logic [31:0] dat = 32'h0,
    // Answer
    input wire logic ack
);
    timeunit 1ns;
    timeprecision 1ns;
    // Hold request until ack, then release; data inverted when released
    task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, i, 2'h0, 4'hF, 24'h0, d};
        do @(posedge clock); while (ack !== 1'b1);
        {cyc, stb, dat} <= {2'b00, ~dat};
        @(posedge clock);
    endtask
    // Mandatory bias pattern
    task automatic bias_init();
        xfer(1'b1, 6'h14, 8'hA3);
    endtask
endmodule // sadc_host_model

// ### verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic fe_valid = 1'b0;
    logic [7:0] fe_estimate = 8'h00;
    // Bus and outputs
    wire cyc, stb, we, ack, hb, pd, osc, rx, tx, amp;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] dat_i, dat_o;
    wire [5:0] swc;
    wire [11:0] mainc, refc;
    wire [1:0] ob, ab;
    wire [2:0] bb;
    wire [3:0] fec;
    // Bookkeeping
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] expq[$];
    logic [7:0] lfsr = 8'h48;
    logic [5:0] ix [6] = '{6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h15};
    logic [7:0] mk [6] = '{8'h3F, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F};
    logic [7:0] v [6];
    sadc_bank u_sadc_bank (
        .clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fe_valid(fe_valid), .fe_estimate(fe_estimate), .alt_swallow_count(swc),
        .alt_main_count(mainc), .alt_ref_count(refc), .halver_high_bias(hb),
        .osc_buffer_bias(ob), .amp_bias(ab), .amp_buffer_bias(bb), .freq_error_ctrl(fec),
        .power_down(pd), .osc_enable(osc), .rx_enable(rx), .tx_enable(tx), .amp_enable(amp)
    );
    sadc_host_model u_sadc_host_model (
        .clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat_i),
        .ack(ack)
    );
    // Clock
    initial forever #20 clock = ~clock;
    // Shift register for random data
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        u_sadc_host_model.xfer(1'b1, i, d);
    endtask
    // Note the expected read data, then read
    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        expq.push_back({24'h0, e});
        u_sadc_host_model.xfer(1'b0, i, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Each acked read against the oldest note
    always @(posedge clock) begin
        if (ack === 1'b1 && we === 1'b0)
            check(dat_o, expq.pop_front());
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        int k;
        logic [1:0] m;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(6'h17, 8'h00);
        $display("Test reset done");
        // Random data with reserved bits set
        for (k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            v[k] = lfsr & mk[k];
            wr(ix[k], lfsr | ~mk[k]);
            rd(ix[k], v[k]);
        end
        check({26'h0, swc}, {24'h0, v[0]});
        check({20'h0, mainc}, {20'h0, v[1][3:0], v[2]});
        check({20'h0, refc}, {20'h0, v[3][3:0], v[4]});
        check({28'h0, fec}, {24'h0, v[5]});
        $display("Test counts done");
        u_sadc_host_model.bias_init();
        @(posedge clock);
        check({24'h0, hb, ob, ab, bb}, 32'hA3);
        rd(6'h14, 8'hA3);
        $display("Test bias done");
        // Modes standby, receive, transmit, down; reserved mode bits set
        for (k = 1; k < 5; k++) begin
            m = k[1:0];
            wr(6'h17, {6'h3F, m});
            @(posedge clock);
            check({pd, rx, tx, amp}, {!m, m == 2'h2, m == 2'h3, 1'b0});
            check(osc, m != 2'h0);
            rd(6'h17, {6'h0, m});
            if (m == 2'h2) begin
                lfsr = next_rand(lfsr);
                fe_estimate <= lfsr;
                fe_valid <= 1'b1;
                @(posedge clock);
                fe_valid <= 1'b0;
                rd(6'h16, lfsr);
                wr(6'h16, ~lfsr);
                rd(6'h16, lfsr);
            end
        end
        rd(6'h11, v[2]);
        check({20'h0, mainc}, {20'h0, v[1][3:0], v[2]});
        $display("Test modes done");
        rd(6'h00, 8'h00);
        rd(6'h3F, 8'h00);
        $display("Test unmapped done");
        tally_and_finish();
    end
endmodule // testbench

// ### verilog/sadc_bank.v
// The Wishbone interface to the registers is this design's own decision.
`include "sadc_defs.vh"

module sadc_bank #(
    parameter MAIN_W = 12,
    parameter SWALLOW_W = 6
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Frequency error estimator result, same clock
    input wire fe_valid,
    input wire [7:0] fe_estimate,
    // Alternate divider set
    output reg [SWALLOW_W-1:0] alt_swallow_count,
    output reg [MAIN_W-1:0] alt_main_count,
    output reg [MAIN_W-1:0] alt_ref_count,
    // Bias fields
    output reg halver_high_bias,
    output reg [1:0] osc_buffer_bias,
    output reg [1:0] amp_bias,
    output reg [2:0] amp_buffer_bias,
    // Estimator control
    output reg [3:0] freq_error_ctrl,
    // Operating state
    output reg power_down,
    output reg osc_enable,
    output reg rx_enable,
    output reg tx_enable,
    output reg amp_enable
);

    // Operating states, binary coded
    localparam ST_DOWN = 2'h0;
    localparam ST_STANDBY = 2'h1;
    localparam ST_RX = 2'h2;
    localparam ST_TX = 2'h3;

    // Bias reset byte; the field outputs reset to slices of it
    localparam [7:0] RST_BIAS = `SADC_RST_BIAS;

    // Decoded bus access
    wire acc_take;
    wire acc_write;
    wire [5:0] acc_index;
    // Byte written by software
    wire [7:0] wr_byte = wb_dat_i[7:0];

    // Stored register bytes, reserved bits held at zero
    reg [7:0] swallow_reg;
    reg [7:0] main_hi_reg;
    reg [7:0] main_lo_reg;
    reg [7:0] ref_hi_reg;
    reg [7:0] ref_lo_reg;
    reg [7:0] bias_reg;
    reg [7:0] fe_ctrl_reg;
    reg [7:0] fe_value_reg;
    reg [1:0] main_mode;
    // Current operating state
    reg [1:0] op_state;
    reg [1:0] next_op_state;
    // Read data chosen for the current access
    reg [7:0] next_rd_byte;

    // Keeps only the writable bits of a byte
    function [7:0] keep_bits;
        input [7:0] value;
        input [7:0] mask;
        begin
            keep_bits = value & mask;
        end
    endfunction

    // True when this access writes the given index
    function hit;
        input [5:0] idx;
        input [5:0] want;
        input wr;
        begin
            hit = wr & (idx == want);
        end
    endfunction

    // Bus front end
    sadc_wb_slave u_slave (
        .clock(clock),
        .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .acc_take(acc_take),
        .acc_write(acc_write),
        .acc_index(acc_index),
        .wb_ack_o(wb_ack_o)
    );

    // Register writes; power down never clears them
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            swallow_reg <= `SADC_RST_ZERO;
            main_hi_reg <= `SADC_RST_ZERO;
            main_lo_reg <= `SADC_RST_ZERO;
            ref_hi_reg <= `SADC_RST_ZERO;
            ref_lo_reg <= `SADC_RST_ZERO;
            bias_reg <= `SADC_RST_BIAS;
            fe_ctrl_reg <= `SADC_RST_ZERO;
            main_mode <= `SADC_RST_MODE;
        end else begin
            // Swallow count, top two bits dropped
            if (hit(acc_index, `SADC_IDX_ALT_SWALLOW, acc_write)) begin
                swallow_reg <= keep_bits(wr_byte, `SADC_MASK_SWALLOW);
            end
            // Main count upper nibble
            if (hit(acc_index, `SADC_IDX_ALT_MAIN_HI, acc_write)) begin
                main_hi_reg <= keep_bits(wr_byte, `SADC_MASK_CNT_HI);
            end
            // Main count lower byte
            if (hit(acc_index, `SADC_IDX_ALT_MAIN_LO, acc_write)) begin
                main_lo_reg <= keep_bits(wr_byte, `SADC_MASK_FULL);
            end
            // Reference count upper nibble
            if (hit(acc_index, `SADC_IDX_ALT_REF_HI, acc_write)) begin
                ref_hi_reg <= keep_bits(wr_byte, `SADC_MASK_CNT_HI);
            end
            // Reference count lower byte
            if (hit(acc_index, `SADC_IDX_ALT_REF_LO, acc_write)) begin
                ref_lo_reg <= keep_bits(wr_byte, `SADC_MASK_FULL);
            end
            // Bias byte stored as written; host supplies the fixed pattern
            if (hit(acc_index, `SADC_IDX_BIAS, acc_write)) begin
                bias_reg <= keep_bits(wr_byte, `SADC_MASK_FULL);
            end
            // Estimator control, low nibble only
            if (hit(acc_index, `SADC_IDX_FE_CTRL, acc_write)) begin
                fe_ctrl_reg <= keep_bits(wr_byte, `SADC_MASK_FE_CTRL);
            end
            // Main mode field
            if (hit(acc_index, `SADC_IDX_MAIN_MODE, acc_write)) begin
                main_mode <= wr_byte[`SADC_MODE_HI_BIT:`SADC_MODE_LO_BIT];
            end
            // Estimate byte and unmapped indexes: the write is dropped
        end
    end

    // Estimate capture; writes to this read-only byte are ignored
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fe_value_reg <= `SADC_RST_ZERO;
        end else if (fe_valid && op_state == ST_RX) begin
            // Estimator only runs while receiving
            fe_value_reg <= fe_estimate;
        end
    end

    // Read data select; unmapped and reserved bits give zero
    always @* begin
        next_rd_byte = 8'h00;
        case (acc_index)
            `SADC_IDX_ALT_SWALLOW: begin
                next_rd_byte = swallow_reg;
            end
            `SADC_IDX_ALT_MAIN_HI: begin
                next_rd_byte = main_hi_reg;
            end
            `SADC_IDX_ALT_MAIN_LO: begin
                next_rd_byte = main_lo_reg;
            end
            `SADC_IDX_ALT_REF_HI: begin
                next_rd_byte = ref_hi_reg;
            end
            `SADC_IDX_ALT_REF_LO: begin
                next_rd_byte = ref_lo_reg;
            end
            `SADC_IDX_BIAS: begin
                next_rd_byte = bias_reg;
            end
            `SADC_IDX_FE_CTRL: begin
                next_rd_byte = fe_ctrl_reg;
            end
            `SADC_IDX_FE_VALUE: begin
                // Bit 7 is the most significant
                next_rd_byte = fe_value_reg;
            end
            `SADC_IDX_MAIN_MODE: begin
                next_rd_byte = {6'h00, main_mode};
            end
            default: begin
                // Unmapped index reads as zero
                next_rd_byte = 8'h00;
            end
        endcase
    end

    // Read data registered with the ack; upper lanes always zero
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (acc_take) begin
            // Loaded at the take edge, stands until the next take
            wb_dat_o <= {24'h000000, next_rd_byte};
        end
    end

    // Next operating state follows the mode field
    always @* begin
        case (main_mode)
            `SADC_MODE_DOWN: begin
                next_op_state = ST_DOWN;
            end
            `SADC_MODE_STANDBY: begin
                next_op_state = ST_STANDBY;
            end
            `SADC_MODE_RX: begin
                next_op_state = ST_RX;
            end
            `SADC_MODE_TX: begin
                next_op_state = ST_TX;
            end
            default: begin
                next_op_state = ST_DOWN;
            end
        endcase
    end

    // Operating state register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            op_state <= ST_DOWN;
        end else begin
            op_state <= next_op_state;
        end
    end

    // Enables decoded from the state, one cycle after it
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            power_down <= 1'b1;
            osc_enable <= 1'b0;
            rx_enable <= 1'b0;
            tx_enable <= 1'b0;
            amp_enable <= 1'b0;
        end else begin
            // Only mode 00 stops everything
            power_down <= (op_state == ST_DOWN);
            // Oscillator runs in every mode but power down
            osc_enable <= (op_state != ST_DOWN);
            // Receive and transmit never overlap
            rx_enable <= (op_state == ST_RX);
            tx_enable <= (op_state == ST_TX);
            // The amplifier stage is never enabled by the mode alone
            amp_enable <= 1'b0;
        end
    end

    // Field outputs, held across power down
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alt_swallow_count <= {SWALLOW_W{1'b0}};
            alt_main_count <= {MAIN_W{1'b0}};
            alt_ref_count <= {MAIN_W{1'b0}};
            halver_high_bias <= RST_BIAS[`SADC_BIAS_HALVER];
            osc_buffer_bias <= RST_BIAS[`SADC_BIAS_OSC_HI:`SADC_BIAS_OSC_LO];
            amp_bias <= RST_BIAS[`SADC_BIAS_AMP_HI:`SADC_BIAS_AMP_LO];
            amp_buffer_bias <= RST_BIAS[`SADC_BIAS_BUF_HI:0];
            freq_error_ctrl <= 4'h0;
        end else begin
            alt_swallow_count <= swallow_reg[SWALLOW_W-1:0];
            // Upper nibble then lower byte
            alt_main_count <= {main_hi_reg[3:0], main_lo_reg};
            alt_ref_count <= {ref_hi_reg[3:0], ref_lo_reg};
            // Bias fields at fixed bit positions of the stored byte
            halver_high_bias <= bias_reg[`SADC_BIAS_HALVER];
            osc_buffer_bias <= bias_reg[`SADC_BIAS_OSC_HI:`SADC_BIAS_OSC_LO];
            amp_bias <= bias_reg[`SADC_BIAS_AMP_HI:`SADC_BIAS_AMP_LO];
            amp_buffer_bias <= bias_reg[`SADC_BIAS_BUF_HI:0];
            // Estimator control, low nibble only
            freq_error_ctrl <= fe_ctrl_reg[3:0];
        end
    end

endmodule // sadc_bank

// ### verilog/sadc_wb_slave.v
`include "sadc_defs.vh"

// Wishbone classic slave front end: one ack per request
module sadc_wb_slave (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Wishbone request
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    // Decoded access toward the register file
    output wire acc_take,
    output wire acc_write,
    output wire [5:0] acc_index,
    // Acknowledge
    output reg wb_ack_o
);

    // Request taken only while no ack stands, so each cycle acks once
    assign acc_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Only the low byte lane carries register data
    assign acc_write = acc_take & wb_we_i & wb_sel_i[0];
    // Word index from the byte address
    assign acc_index = wb_adr_i[7:2];

    // Ack follows the take edge and drops the next cycle
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc_take;
        end
    end

endmodule // sadc_wb_slave
